// ---- inc/eeecw_pkg.sv ----
package eeecw_pkg;

  // ****************************************
  // Indirect access map
  // ****************************************
  localparam logic [7:0] ADDR_IND_SELECT = 8'h6e;
  localparam logic [7:0] ADDR_IND_OFFSET = 8'h6f;
  localparam logic [7:0] ADDR_IND_DATA   = 8'ha0;
  localparam logic [2:0] TABLE_EEE       = 3'h1;
  localparam int         SEL_TABLE_HI    = 7;
  localparam int         SEL_TABLE_LO    = 5;
  localparam int         SEL_PORT_HI     = 3;
  localparam logic [3:0] PORT_FIRST      = 4'h1;
  localparam logic [3:0] PORT_LAST       = 4'h3;
  localparam int         NUM_PORTS       = 3;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_CAP_HI  = 8'h28;
  localparam logic [7:0] OFS_CAP_LO  = 8'h29;
  localparam logic [7:0] OFS_WAKE_HI = 8'h2a;
  localparam logic [7:0] OFS_WAKE_LO = 8'h2b;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int          CAP_LP_HI       = 14;
  localparam int          CAP_LP_LO       = 9;
  localparam int          CAP_LOCAL_TX    = 1;
  localparam logic        RST_LOCAL_TX    = 1'b1;
  localparam logic [5:0]  RST_LP_CAP      = 6'h00;
  localparam logic [15:0] RST_WAKE_COUNT  = 16'h0000;
  localparam logic [15:0] WAKE_COUNT_MAX  = 16'hffff;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS       = 40;
  localparam int WAKE_THRESHOLD_PS   = 20500000;
  localparam int WAKE_THRESHOLD_CYC  = WAKE_THRESHOLD_PS / (CLK_PERIOD_NS * 1000);
  localparam int WAKE_TIMER_WIDTH    = 16;

endpackage

// ---- rtl/eeecw_port.sv ----
`timescale 1ns/100ps
module eeecw_port
  import eeecw_pkg::*;
#(
  parameter int TIMER_WIDTH = WAKE_TIMER_WIDTH
) (
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  input  wire logic                   lpiActive,
  input  wire logic [TIMER_WIDTH-1:0] wakeThreshold,
  input  wire logic                   capLoad,
  input  wire logic [5:0]             capIn,
  input  wire logic                   readClear,
  output logic      [5:0]             linkPartnerCap,
  output logic      [15:0]            wakeCount
);

  typedef enum logic [1:0] {ST_IDLE, ST_LPI, ST_WAKE} eeecw_wake_type;

  eeecw_wake_type             state;
  logic [TIMER_WIDTH-1:0]     timer;
  logic                       wakeError;

  // ****************************************
  // Wake tracking
  // ****************************************
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state <= ST_IDLE;
      timer <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (lpiActive) begin
            state <= ST_LPI;
          end
        end
        ST_LPI: begin
          timer <= '0;
          if (!lpiActive) begin
            state <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (lpiActive) begin
            state <= ST_LPI;
          end else if (timer == wakeThreshold) begin
            state <= ST_IDLE;
          end else begin
            timer <= timer + 1'b1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  assign wakeError = (state == ST_WAKE) && !lpiActive && (timer == wakeThreshold);

  // ****************************************
  // Counter
  // ****************************************
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wakeCount <= RST_WAKE_COUNT;
    end else if (readClear) begin
      wakeCount <= wakeError ? 16'h0001 : RST_WAKE_COUNT;
    end else if (wakeError && wakeCount != WAKE_COUNT_MAX) begin
      wakeCount <= wakeCount + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      linkPartnerCap <= RST_LP_CAP;
    end else if (capLoad) begin
      linkPartnerCap <= capIn;
    end
  end

endmodule

// ---- rtl/eeecw_regs.sv ----
`timescale 1ns/100ps
// Operation
// - Select bits 3:0 pick port 1-3
// - Selected byte appears at 0xA0
// - Capability at offsets 0x28 and 0x29
// - Bits 14:12 partner KR/KX4/KX capability
// - Bits 11:9 partner T/1000T/100TX capability
// - Bit 1 local 100TX advertisement, reset 1
// - Wake counter at offsets 0x2A and 0x2B
// - Count wakes longer than threshold
// - Threshold defaults to 20.5 us
// - Reading low byte at 0x2B clears counter
module eeecw_regs
  import eeecw_pkg::*;
#(
  parameter int TIMER_WIDTH = WAKE_TIMER_WIDTH
) (
  input  wire logic                        clk_sys,
  input  wire logic                        reset,
  input  wire logic [7:0]                  regAddr,
  input  wire logic [7:0]                  regWdata,
  input  wire logic                        regWrite,
  input  wire logic                        regRead,
  output logic      [7:0]                  regRdata,
  input  wire logic [TIMER_WIDTH-1:0]      wakeThreshold,
  input  wire logic [NUM_PORTS-1:0]        lpiActive,
  input  wire logic [NUM_PORTS-1:0]        capLoad,
  input  wire logic [NUM_PORTS*6-1:0]      capIn,
  output logic      [NUM_PORTS-1:0]      localTxAdvertise
);

  typedef enum logic [2:0] {BYTE_NONE, BYTE_CAP_HI, BYTE_CAP_LO, BYTE_WAKE_HI, BYTE_WAKE_LO} eeecw_byte_type;

  logic [7:0]              selectReg;
  logic [7:0]              offsetReg;
  logic [NUM_PORTS-1:0]    readClear;
  logic [NUM_PORTS-1:0]    portSel;
  logic [5:0]              lpCap [NUM_PORTS];
  logic [15:0]             wakeCount [NUM_PORTS];
  logic                    eeeSelected;
  logic                    portValid;
  logic [1:0]              portIdx;
  logic                    dataHit;
  logic                    dataRead;
  logic                    dataWrite;
  eeecw_byte_type          byteSel;
  logic [15:0]             capWord;
  logic [15:0]             wakeWord;
  logic [7:0]              dataByte;
  logic [7:0]              next_rdata;

  // ****************************************
  // Indirect select
  // ****************************************
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      selectReg <= 8'h00;
    end else if (regWrite && regAddr == ADDR_IND_SELECT) begin
      selectReg <= regWdata;
    end
  end

  // ****************************************
  // Indirect offset
  // ****************************************
  // offset byte write
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      offsetReg <= 8'h00;
    end else if (regWrite && regAddr == ADDR_IND_OFFSET) begin
      offsetReg <= regWdata;
    end
  end

  // ****************************************
  // Access decode
  // ****************************************
  // table decode
  assign eeeSelected = selectReg[SEL_TABLE_HI:SEL_TABLE_LO] == TABLE_EEE;
  assign portValid   = selectReg[SEL_PORT_HI:0] >= PORT_FIRST
                       && selectReg[SEL_PORT_HI:0] <= PORT_LAST;
  assign portIdx     = 2'(selectReg[SEL_PORT_HI:0] - PORT_FIRST);
  assign dataHit     = regAddr == ADDR_IND_DATA && eeeSelected && portValid;
  assign dataRead    = regRead && dataHit;
  assign dataWrite   = regWrite && dataHit;

  // ****************************************
  // Offset decode
  // ****************************************
  always_comb begin
    case (offsetReg)
      OFS_CAP_HI:  byteSel = BYTE_CAP_HI;
      OFS_CAP_LO:  byteSel = BYTE_CAP_LO;
      OFS_WAKE_HI: byteSel = BYTE_WAKE_HI;
      OFS_WAKE_LO: byteSel = BYTE_WAKE_LO;
      default:     byteSel = BYTE_NONE;
    endcase
  end

  // ****************************************
  // Local advertisement
  // ****************************************
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      localTxAdvertise <= {NUM_PORTS{RST_LOCAL_TX}};
    end else if (dataWrite && byteSel == BYTE_CAP_LO) begin
      localTxAdvertise[portIdx] <= regWdata[CAP_LOCAL_TX];
    end
  end

  // ****************************************
  // Per-port logic
  // ****************************************
  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : gPort
      assign portSel[p]   = portIdx == 2'(p);
      assign readClear[p] = dataRead && portSel[p] && byteSel == BYTE_WAKE_LO;
      eeecw_port #(
        .TIMER_WIDTH (TIMER_WIDTH)
      ) uPort (
        .clk_sys        (clk_sys),
        .reset          (reset),
        .lpiActive      (lpiActive[p]),
        .wakeThreshold  (wakeThreshold),
        .capLoad        (capLoad[p]),
        .capIn          (capIn[p*6 +: 6]),
        .readClear      (readClear[p]),
        .linkPartnerCap (lpCap[p]),
        .wakeCount      (wakeCount[p])
      );
    end
  endgenerate

  // ****************************************
  // Port words
  // ****************************************
  always_comb begin
    capWord = 16'h0000;
    if (portValid) begin
      capWord[CAP_LP_HI:CAP_LP_LO] = lpCap[portIdx];
      capWord[CAP_LOCAL_TX]        = localTxAdvertise[portIdx];
    end
  end

  always_comb begin
    wakeWord = 16'h0000;
    if (portValid) begin
      wakeWord = wakeCount[portIdx];
    end
  end

  // ****************************************
  // Indirect byte mux
  // ****************************************
  // indirect byte mux
  always_comb begin
    case (byteSel)
      BYTE_CAP_HI: begin
        dataByte = capWord[15:8];
      end
      BYTE_CAP_LO: begin
        dataByte = capWord[7:0];
      end
      BYTE_WAKE_HI: begin
        dataByte = wakeWord[15:8];
      end
      BYTE_WAKE_LO: begin
        dataByte = wakeWord[7:0];
      end
      default: begin
        dataByte = 8'h00;
      end
    endcase
  end

  // ****************************************
  // Read data select
  // ****************************************
  always_comb begin
    case (regAddr)
      ADDR_IND_SELECT: begin
        next_rdata = selectReg;
      end
      ADDR_IND_OFFSET: begin
        next_rdata = offsetReg;
      end
      ADDR_IND_DATA: begin
        next_rdata = 8'h00;
        if (dataHit) begin
          next_rdata = dataByte;
        end
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // ****************************************
  // Read data register
  // ****************************************
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      regRdata <= next_rdata;
    end
  end

endmodule

// ---- dv/eeecw_checker.sv ----
`timescale 1ns/100ps
module eeecw_checker
  import eeecw_pkg::*;
(
  input wire logic                 clk_sys,
  input wire logic                 reset,
  input wire logic [7:0]           regAddr,
  input wire logic [7:0]           regWdata,
  input wire logic                 regWrite,
  input wire logic                 regRead,
  input wire logic [7:0]           regRdata,
  input wire logic [NUM_PORTS-1:0] localTxAdvertise
);
  // ****************************************
  // Shadow of select and offset
  // ****************************************
  logic [7:0] sel;
  logic [7:0] ofs;
  logic       ok;
  logic       dr;
  logic       txw;
  logic [1:0] txIdx;
  logic       curTx;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sel <= 8'h00;
      ofs <= 8'h00;
    end else begin
      if (regWrite && regAddr == ADDR_IND_SELECT) begin
        sel <= regWdata;
      end
      if (regWrite && regAddr == ADDR_IND_OFFSET) begin
        ofs <= regWdata;
      end
    end
  end
  assign ok = sel[7:5] == TABLE_EEE && sel[3:0] >= PORT_FIRST && sel[3:0] <= PORT_LAST;
  assign dr = regRead && regAddr == ADDR_IND_DATA;
  assign txw = regWrite && regAddr == ADDR_IND_DATA && ok && ofs == OFS_CAP_LO;
  assign txIdx = sel[1:0] - 2'h1;
  assign curTx = localTxAdvertise[txIdx];
  AST_RD_HOLD: assert property (!regRead |=> $stable(regRdata))
    else $error("read data changed without a read");
  AST_TX_HOLD: assert property (!txw |=> $stable(localTxAdvertise))
    else $error("advertisement changed without a valid write");
  AST_TX_WR: assert property (txw |=> localTxAdvertise[$past(txIdx)] == $past(regWdata[1]))
    else $error("advertisement not taken from write data");
  AST_SEL_RD: assert property (regRead && regAddr == 8'h6e |=> regRdata == $past(sel))
    else $error("select register readback wrong");
  AST_OFS_RD: assert property (regRead && regAddr == 8'h6f |=> regRdata == $past(ofs))
    else $error("offset register readback wrong");
  AST_BAD_SEL: assert property (dr && !ok |=> regRdata == 8'h00)
    else $error("data read with invalid select not zero");
  AST_CAP_HI: assert property (dr && ok && ofs == 8'h28 |=> !regRdata[7] && !regRdata[0])
    else $error("reserved capability bits set");
  AST_CAP_LO: assert property (dr && ok && ofs == 8'h29 |=>
    regRdata == {6'h00, $past(curTx), 1'b0})
    else $error("capability low byte wrong");
endmodule
bind eeecw_regs eeecw_checker i_eeecw_checker (
  .clk_sys(clk_sys), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
  .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
  .localTxAdvertise(localTxAdvertise)
);

// ---- dv/eeecw_regs_bench.sv ----
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module eeecw_regs_bench
  import eeecw_pkg::*;
;
  // ****************************************
  // Stimulus and checks
  // ****************************************
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  regAddr = 8'h00;
  logic [7:0]  regWdata = 8'h00;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [7:0]  regRdata;
  logic [15:0] wakeThreshold = 16'(WAKE_THRESHOLD_CYC);
  logic [2:0]  lpiActive = 3'h0;
  logic [2:0]  capLoad = 3'h0;
  logic [17:0] capIn = 18'h00000;
  logic [2:0]  localTxAdvertise;
  logic [5:0]  pat;
  logic [7:0]  bad [3] = '{8'h20, 8'h24, 8'h41};
  int          fail_count = 0;
  int          total_checks = 0;
  always #20 clk_sys = ~clk_sys;
  eeecw_regs #(.TIMER_WIDTH(16)) i_eeecw_regs (
    .clk_sys(clk_sys), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .wakeThreshold(wakeThreshold), .lpiActive(lpiActive), .capLoad(capLoad),
    .capIn(capIn), .localTxAdvertise(localTxAdvertise)
  );
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_sys);
    regAddr = a;
    regWdata = v;
    regWrite = 1'b1;
    @(negedge clk_sys);
    regWrite = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    regAddr = a;
    regRead = 1'b1;
    @(negedge clk_sys);
    regRead = 1'b0;
    `CHK(regRdata, e)
  endtask
  task automatic ind(input logic [7:0] s, input logic [7:0] o);
    wr(8'h6e, s);
    wr(8'h6f, o);
  endtask
  task automatic wake(input logic [15:0] th, input int n);
    lpiActive[2] = 1'b1;
    wakeThreshold = th;
    repeat (3) @(negedge clk_sys);
    lpiActive[2] = 1'b0;
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk_sys);
    fail_count++;
    results();
  end
  initial begin
    repeat (20) @(negedge clk_sys);
    reset = 1'b0;
    ind(8'h21, 8'h29);
    rd(8'h6e, 8'h21);
    rd(8'h6f, 8'h29);
    rd(8'ha0, 8'h02);
    ind(8'h21, 8'h28);
    rd(8'ha0, 8'h00);
    for (int p = 1; p <= 3; p++) begin
      pat = 6'h25 ^ 6'(p * 9);
      capIn[(p-1)*6 +: 6] = pat;
      capLoad[p-1] = 1'b1;
      @(negedge clk_sys);
      capLoad[p-1] = 1'b0;
      capIn = ~capIn;
      ind(8'h20 | 8'(p), 8'h28);
      rd(8'ha0, {1'b0, pat, 1'b0});
    end
    ind(8'h22, 8'h29);
    wr(8'ha0, 8'hfd);
    `CHK(localTxAdvertise, 3'b101)
    rd(8'ha0, 8'h00);
    wr(8'ha0, 8'h02);
    rd(8'ha0, 8'h02);
    foreach (bad[i]) begin
      ind(bad[i], 8'h29);
      wr(8'ha0, 8'h00);
      rd(8'ha0, 8'h00);
      `CHK(localTxAdvertise, 3'b111)
    end
    wake(16'(WAKE_THRESHOLD_CYC), 520);
    wake(16'(WAKE_THRESHOLD_CYC), 500);
    wake(16'h0008, 4);
    wake(16'h0008, 12);
    ind(8'h23, 8'h2a);
    rd(8'ha0, 8'h00);
    ind(8'h23, 8'h2b);
    rd(8'ha0, 8'h02);
    rd(8'ha0, 8'h00);
    ind(8'h21, 8'h2b);
    rd(8'ha0, 8'h00);
    results();
  end
endmodule
